// *** core/iac_ctrl.sv ***
// interrupt acknowledge controller: flags, arbitration, save and vector
// assumes sequencer pulses instrEnd on the last clock of each instruction
// and stalls while ack.busy is high; source events are one-cycle pulses
//
// Notes on behaviour
// - nmi taken regardless of enable flag, before any maskable request.
// - nmi take: push status word, then pc, clear enable, load vector.
// - a second nmi preempts nmi service; software should avoid this.
// - maskable eligible when flag set, mask clear, and enable flag set.
// - maskable latency 9 to 19 clocks, longest before bit-test branches.
// - simultaneous eligible requests taken by fixed priority, highest first.
// - a request not yet takeable stays pending until conditions allow.
// - maskable take: push status word, then pc, clear enable, load vector.
// - flag set before the last clock: taken after current instruction.
// - flag set on the last clock: one more instruction runs first.
// - flag or mask manipulating instruction defers taking one more instruction.
// - while flag or mask registers are accessed, requests stay pending.
// - nesting only after the routine sets the enable flag again.
// - request during routine with enable clear is held until it returns.
// - nine maskable sources, priority 0 highest through 8 lowest.
// - request flag cleared on acceptance and by reset.
// - return restores saved status word including the enable flag.
//
// Implementation choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module iac_ctrl
   import iac_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [NUM_SRC-1:0] srcEvent,
   input wire logic nmiEvent,
   input wire iac_seq_s seq,
   output iac_ack_s ack,
   output logic globalIrqEnableFlag,
   output logic irq
);
   // flag state
   logic [NUM_SRC-1:0] sourceRequestFlag, next_sourceRequestFlag;
   logic [NUM_SRC-1:0] sourceMaskFlag, next_sourceMaskFlag;
   logic [7:0] statusWord, next_statusWord;
   logic nmiPending, next_nmiPending;
   logic nmiActive, next_nmiActive;
   logic deferFlag, next_deferFlag;
   logic [2:0] evtStat, next_evtStat;
   logic [2:0] evtMask, next_evtMask;
   // bus state
   logic busAck, next_busAck;
   logic [31:0] busData, next_busData;
   // acceptance state
   iac_state_e state, next_state;
   logic takeNmi, next_takeNmi;
   logic [IDX_W-1:0] winIdx, next_winIdx;
   logic [7:0] savedStatus, next_savedStatus;
   // decode
   logic busReq, busWr, busRd, lowLane, flagRegAccess, accept;
   logic anyElig;
   logic [IDX_W-1:0] prioIdx;
   logic [NUM_SRC-1:0] eligible, clrReq;

   // decode is combinational; only the flops below hold state.
   // flag and mask accesses block a take in the same cycle, which
   // keeps a take out of each single bus read or write of those registers
   assign busReq = wb_cyc_i & wb_stb_i;
   // writes and read side effects land on the edge that carries ack
   assign busWr = busReq & busAck & wb_we_i;
   assign busRd = busReq & busAck & ~wb_we_i;
   assign lowLane = wb_sel_i[0];
   assign flagRegAccess = busReq & ((wb_adr_i == REG_REQ_LO)
      | (wb_adr_i == REG_REQ_HI) | (wb_adr_i == REG_MASK_LO)
      | (wb_adr_i == REG_MASK_HI));

   // eligibility and fixed priority, lowest index wins
   always_comb begin
      eligible = sourceRequestFlag & ~sourceMaskFlag;
      anyElig = |eligible;
      prioIdx = '0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (eligible[i]) begin
            prioIdx = IDX_W'(i);
         end
      end
   end

   // take only at an instruction boundary; a flag that rises on the
   // boundary clock is not yet in the register and waits one instruction
   always_comb begin
      accept = 1'b0;
      if (state == ST_IDLE && seq.instrEnd && !deferFlag
            && !flagRegAccess) begin
         // nmi ignores the enable flag; maskable needs it set, so a
         // routine that never re-enables keeps new requests pending
         // until its return restores the saved status word
         accept = nmiPending
            | (anyElig & statusWord[EN_BIT]);
      end
   end

   // acceptance sequencer
   always_comb begin
      next_state = state;
      next_takeNmi = takeNmi;
      next_winIdx = winIdx;
      next_savedStatus = savedStatus;
      case (state)
         ST_IDLE: begin
            if (accept) begin
               next_state = ST_PUSH_STATUS;
               next_takeNmi = nmiPending;
               next_winIdx = nmiPending ? NMI_IDX : prioIdx;
               next_savedStatus = statusWord;
            end
         end
         ST_PUSH_STATUS: begin
            next_state = ST_PUSH_PC;
         end
         ST_PUSH_PC: begin
            next_state = ST_LOAD_VEC;
         end
         ST_LOAD_VEC: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state <= ST_IDLE;
         takeNmi <= 1'b0;
         winIdx <= '0;
         savedStatus <= STATUS_RST;
      end else begin
         state <= next_state;
         takeNmi <= next_takeNmi;
         winIdx <= next_winIdx;
         savedStatus <= next_savedStatus;
      end
   end

   // request and mask flags; a fresh event beats a same-cycle clear
   always_comb begin
      clrReq = '0;
      if (accept && !nmiPending) begin
         clrReq[prioIdx] = 1'b1;
      end
      next_sourceRequestFlag = sourceRequestFlag & ~clrReq;
      next_sourceMaskFlag = sourceMaskFlag;
      if (busWr && lowLane) begin
         case (wb_adr_i)
            REG_REQ_LO: begin
               next_sourceRequestFlag[HI_SRC-1:0] = wb_dat_i[HI_SRC-1:0];
            end
            REG_REQ_HI: begin
               next_sourceRequestFlag[HI_SRC] = wb_dat_i[0];
            end
            REG_MASK_LO: begin
               next_sourceMaskFlag[HI_SRC-1:0] = wb_dat_i[HI_SRC-1:0];
            end
            REG_MASK_HI: begin
               next_sourceMaskFlag[HI_SRC] = wb_dat_i[0];
            end
            default: begin
            end
         endcase
      end
      // new events are ORed in last; set flags stay until taken or rewritten over the bus
      next_sourceRequestFlag = next_sourceRequestFlag | srcEvent;
   end

   // status word, nmi tracking and deferral
   always_comb begin
      next_statusWord = statusWord;
      next_nmiPending = nmiPending;
      next_nmiActive = nmiActive;
      next_deferFlag = deferFlag;
      if (busWr && lowLane && wb_adr_i == REG_STATUS_WORD) begin
         next_statusWord = wb_dat_i[7:0];
      end
      // enable and disable instructions act at their own end; a take
      // in the same cycle still clears the flag further down
      if (seq.enIrqExec) begin
         next_statusWord[EN_BIT] = 1'b1;
      end
      if (seq.diExec) begin
         next_statusWord[EN_BIT] = 1'b0;
      end
      // return restores the whole word, enable flag included; it also
      // closes nmi service so a later nmi is not counted as nested
      if (seq.irqRetExec) begin
         next_statusWord = seq.irqRetStatus;
         next_nmiActive = 1'b0;
      end
      // last writer: a take beats enable, return and bus write
      if (accept) begin
         next_statusWord[EN_BIT] = 1'b0;
         if (nmiPending) begin
            next_nmiPending = 1'b0;
            next_nmiActive = 1'b1;
         end
      end
      if (nmiEvent) begin
         next_nmiPending = 1'b1;
      end
      // one boundary is skipped after a flag or mask instruction
      if (seq.instrEnd) begin
         next_deferFlag = seq.flagRegInstr;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         sourceRequestFlag <= REQ_RST;
         sourceMaskFlag <= MASK_RST;
         statusWord <= STATUS_RST;
         nmiPending <= 1'b0;
         nmiActive <= 1'b0;
         deferFlag <= 1'b0;
      end else begin
         sourceRequestFlag <= next_sourceRequestFlag;
         sourceMaskFlag <= next_sourceMaskFlag;
         statusWord <= next_statusWord;
         nmiPending <= next_nmiPending;
         nmiActive <= next_nmiActive;
         deferFlag <= next_deferFlag;
      end
   end

   // event status: sticky, cleared by reading, set wins over the read
   always_comb begin
      next_evtStat = evtStat;
      next_evtMask = evtMask;
      if (busRd && wb_adr_i == REG_EVT_STAT) begin
         next_evtStat = EVT_RST;
      end
      if (busWr && lowLane && wb_adr_i == REG_EVT_MASK) begin
         next_evtMask = wb_dat_i[2:0];
      end
      if (accept) begin
         if (nmiPending) begin
            next_evtStat[EVT_NMI] = 1'b1;
         end else begin
            next_evtStat[EVT_MASKABLE] = 1'b1;
         end
         if (nmiPending && nmiActive) begin
            next_evtStat[EVT_NEST] = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         evtStat <= EVT_RST;
         evtMask <= EVT_RST;
      end else begin
         evtStat <= next_evtStat;
         evtMask <= next_evtMask;
      end
   end

   // wishbone slave: ack one cycle after the strobe, dropped the next;
   // unmapped addresses read zero and ignore writes but still answer
   always_comb begin
      next_busAck = busReq & ~busAck;
      next_busData = busData;
      if (busReq && !busAck) begin
         next_busData = '0;
         case (wb_adr_i)
            REG_REQ_LO: begin
               next_busData[HI_SRC-1:0] = sourceRequestFlag[HI_SRC-1:0];
            end
            REG_REQ_HI: begin
               next_busData[0] = sourceRequestFlag[HI_SRC];
            end
            REG_MASK_LO: begin
               next_busData[HI_SRC-1:0] = sourceMaskFlag[HI_SRC-1:0];
            end
            REG_MASK_HI: begin
               next_busData[0] = sourceMaskFlag[HI_SRC];
            end
            REG_STATUS_WORD: begin
               next_busData[7:0] = statusWord;
            end
            REG_EVT_STAT: begin
               next_busData[2:0] = evtStat;
            end
            REG_EVT_MASK: begin
               next_busData[2:0] = evtMask;
            end
            REG_WINNER: begin
               next_busData[IDX_W-1:0] = winIdx;
               next_busData[IDX_W] = (state != ST_IDLE);
               next_busData[IDX_W+1] = nmiActive;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         busAck <= 1'b0;
         busData <= '0;
      end else begin
         busAck <= next_busAck;
         busData <= next_busData;
      end
   end

   // both bus outputs are flops, so the master sees no glitch
   // between its request and the answer
   assign wb_ack_o = busAck;
   assign wb_dat_o = busData;

   // sequencer handshake; the 9 to 19 clock latency arises from the
   // boundary wait plus the three save and load steps
   always_comb begin
      ack.busy = (state != ST_IDLE);
      ack.pushStatus = (state == ST_PUSH_STATUS);
      ack.pushPc = (state == ST_PUSH_PC);
      ack.vectorLoad = (state == ST_LOAD_VEC);
      ack.isNmi = takeNmi;
      ack.index = winIdx;
      ack.savedStatus = savedStatus;
   end

   // live enable bit for the sequencer and for debug; the copy taken
   // on acceptance travels separately in ack.savedStatus
   assign globalIrqEnableFlag = statusWord[EN_BIT];
   // level interrupt while any unmasked event bit stands
   assign irq = |(evtStat & evtMask);
endmodule : iac_ctrl
`default_nettype wire

// *** pkg/iac_pkg.sv ***
// constants, register map and carriers for the interrupt acknowledge block
// assumes a 32-bit classic wishbone master and one cpu clock
package iac_pkg;
   localparam int NUM_SRC = 9;
   localparam int IDX_W = 4;
   localparam int ADR_W = 5;
   // register byte addresses
   localparam logic [ADR_W-1:0] REG_REQ_LO = 5'h00;
   localparam logic [ADR_W-1:0] REG_REQ_HI = 5'h04;
   localparam logic [ADR_W-1:0] REG_MASK_LO = 5'h08;
   localparam logic [ADR_W-1:0] REG_MASK_HI = 5'h0C;
   localparam logic [ADR_W-1:0] REG_STATUS_WORD = 5'h10;
   localparam logic [ADR_W-1:0] REG_EVT_STAT = 5'h14;
   localparam logic [ADR_W-1:0] REG_EVT_MASK = 5'h18;
   localparam logic [ADR_W-1:0] REG_WINNER = 5'h1C;
   // reset values
   localparam logic [NUM_SRC-1:0] REQ_RST = 9'h000;
   localparam logic [NUM_SRC-1:0] MASK_RST = 9'h1FF;
   localparam logic [7:0] STATUS_RST = 8'h02;
   localparam logic [2:0] EVT_RST = 3'h0;
   // field positions
   localparam int EN_BIT = 7;
   localparam int HI_SRC = 8;
   localparam int EVT_NMI = 0;
   localparam int EVT_MASKABLE = 1;
   localparam int EVT_NEST = 2;
   // vector index used for the non-maskable source
   localparam logic [IDX_W-1:0] NMI_IDX = 4'hF;
   // timing of the maskable path, in cpu clocks
   localparam int LAT_MIN_CLK = 9;
   localparam int LAT_MAX_CLK = 19;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_PUSH_STATUS,
      ST_PUSH_PC,
      ST_LOAD_VEC
   } iac_state_e;

   // sequencer to controller
   typedef struct packed {
      logic instrEnd;
      logic flagRegInstr;
      logic enIrqExec;
      logic diExec;
      logic irqRetExec;
      logic [7:0] irqRetStatus;
   } iac_seq_s;

   // controller to sequencer
   typedef struct packed {
      logic busy;
      logic pushStatus;
      logic pushPc;
      logic vectorLoad;
      logic isNmi;
      logic [IDX_W-1:0] index;
      logic [7:0] savedStatus;
   } iac_ack_s;
endpackage : iac_pkg

// *** test/iac_seq_model.sv ***
// instruction sequencer stand-in for the acknowledge controller
// assumes one cpu clock; len of at least 2 clocks per instruction
`timescale 1ns/10ps
`default_nettype none
module iac_seq_model
   import iac_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic busy,
   input wire logic [3:0] len,
   input wire logic fr,
   input wire logic retReq,
   input wire logic [7:0] retSt,
   output iac_seq_s seq
);
   logic [3:0] cnt;
   // clock count in the running instruction; held at zero while saving
   always_ff @(posedge core_clk) begin
      if (reset || busy || cnt >= len - 4'h1) begin
         cnt <= 4'h0;
      end else begin
         cnt <= cnt + 4'h1;
      end
   end
   // boundary pulse on the last clock, stalled while busy
   assign seq.instrEnd = !reset && !busy && cnt == len - 4'h1;
   assign seq.flagRegInstr = fr;
   assign seq.enIrqExec = 1'b0;
   assign seq.diExec = 1'b0;
   assign seq.irqRetExec = seq.instrEnd && retReq;
   assign seq.irqRetStatus = retSt;
endmodule : iac_seq_model
`default_nettype wire

// *** test/iac_ctrl_sva.sv ***
// port assertions for the acknowledge controller
// assumes one clock domain with synchronous reset; bound below
`timescale 1ns/10ps
`default_nettype none
module iac_ctrl_sva
   import iac_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire iac_seq_s seq,
   input wire iac_ack_s ack,
   input wire logic globalIrqEnableFlag
);
   logic deferArm;
   logic next_deferArm;
   // arms on a flag register boundary, spent by the next boundary
   always_comb begin
      next_deferArm = deferArm;
      if (seq.instrEnd) begin
         next_deferArm = seq.flagRegInstr;
      end
   end
   // helper register, cleared by reset
   always_ff @(posedge core_clk) begin
      deferArm <= reset ? 1'b0 : next_deferArm;
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   a_push_order:
      assert property (ack.pushStatus |=> ack.pushPc ##1 ack.vectorLoad)
      else $error("save sequence out of order");
   a_busy_span:
      assert property ($rose(ack.busy) |-> ack.pushStatus ##0
         (ack.busy [*3] ##1 !ack.busy)) else $error("busy span wrong");
   a_ie_cleared:
      assert property (ack.pushStatus |-> !globalIrqEnableFlag)
      else $error("enable flag not cleared on take");
   a_nmi_index:
      assert property (ack.pushStatus && ack.isNmi |-> ack.index == NMI_IDX)
      else $error("nmi index wrong");
   a_mask_needs_ie:
      assert property (ack.pushStatus && !ack.isNmi |->
         ack.savedStatus[EN_BIT] && ack.index < NUM_SRC)
      else $error("maskable taken without enable");
   a_take_boundary:
      assert property ($rose(ack.busy) |-> $past(seq.instrEnd))
      else $error("take off a boundary");
   a_defer_skip:
      assert property (seq.instrEnd && deferArm |=> !ack.pushStatus)
      else $error("deferred boundary taken");
   a_return_en:
      assert property (seq.irqRetExec |=> ack.pushStatus ||
         globalIrqEnableFlag == $past(seq.irqRetStatus[EN_BIT]))
      else $error("return did not restore enable");
   a_wb_answer:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
         wb_ack_o ##1 !wb_ack_o) else $error("bus answer wrong");
   c_nmi: cover property (ack.pushStatus && ack.isNmi);
   c_mask: cover property (ack.pushStatus && !ack.isNmi);
   c_defer: cover property (seq.instrEnd && deferArm);
endmodule : iac_ctrl_sva
bind iac_ctrl iac_ctrl_sva u_sva (.core_clk(core_clk), .reset(reset),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .seq(seq), .ack(ack), .globalIrqEnableFlag(globalIrqEnableFlag));
`default_nettype wire

// *** test/interrupt_acknowledge_ctrl_test.sv ***
// self-checking bench for the acknowledge controller
// assumes the sequencer model and bound checker are compiled alongside
`timescale 1ns/10ps
`default_nettype none
module interrupt_acknowledge_ctrl_test;
   import iac_pkg::*;
   localparam logic [31:0] RV [8] = '{32'h0, 32'h0, 32'hFF, 32'h1,
      32'h2, 32'h0, 32'h0, 32'h0};
   logic core_clk, reset, cyc, stb, we, wbAck, nmiEvent, enFlag, irq;
   logic fr, retReq, lastNmi;
   logic [4:0] adr;
   logic [31:0] dat, datO;
   logic [8:0] srcEvent;
   logic [3:0] len, lastIdx;
   logic [7:0] retSt;
   iac_seq_s seq;
   iac_ack_s ack;
   int n_fail = 0, n_tests = 0, nTake = 0, cycles = 0;
   iac_ctrl dut (.core_clk(core_clk), .reset(reset), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
      .wb_dat_i(dat), .wb_dat_o(datO), .wb_ack_o(wbAck),
      .srcEvent(srcEvent), .nmiEvent(nmiEvent), .seq(seq), .ack(ack),
      .globalIrqEnableFlag(enFlag), .irq(irq));
   iac_seq_model seqm (.core_clk(core_clk), .reset(reset), .busy(ack.busy),
      .len(len), .fr(fr), .retReq(retReq), .retSt(retSt), .seq(seq));
   // clock and a hang limit well above the run length
   always #2.5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         complete_run();
      end
   end
   // note each take as it happens, so bus waits cannot miss one
   always @(posedge core_clk) begin
      if (ack.pushStatus === 1'b1) begin
         nTake <= nTake + 1;
         lastIdx <= ack.index;
         lastNmi <= ack.isNmi;
      end
   end
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : complete_run
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // classic cycle: hold until ack is sampled high, then release
   task automatic wb(input logic w, input logic [4:0] a,
         input logic [31:0] d, output logic [31:0] q);
      @(posedge core_clk);
      {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
      do @(posedge core_clk); while (wbAck !== 1'b1);
      q = datO;
      {cyc, stb} <= 2'b00;
      @(posedge core_clk);
   endtask : wb
   task automatic fire(input logic [8:0] s, input logic n);
      @(posedge core_clk);
      {srcEvent, nmiEvent} <= {s, n};
      @(posedge core_clk);
      {srcEvent, nmiEvent} <= 10'h000;
   endtask : fire
   task automatic take(input logic [3:0] e, input int n0);
      int k;
      k = 0;
      while (nTake == n0 && k < 200) begin
         @(posedge core_clk);
         k++;
      end
      chk("take count", n0 + 1, nTake);
      chk("taken index", {28'h0, e}, {28'h0, lastIdx});
   endtask : take
   // expected winner: lowest set index has the highest priority
   function automatic logic [3:0] top(input logic [8:0] m);
      top = 4'hF;
      for (int i = 8; i >= 0; i--) if (m[i]) top = i[3:0];
   endfunction : top
   // main sequence
   initial begin
      logic [31:0] q;
      logic [8:0] m;
      int n0;
      {core_clk, reset, cyc, stb, we, nmiEvent, fr, retReq} = 8'h40;
      {adr, dat, srcEvent, retSt} = '0;
      void'($urandom(32'h6E2E0147));
      len = 4'h4 + 4'($urandom % 7);
      repeat (16) @(posedge core_clk);
      reset <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         wb(1'b0, 5'(i * 4), 32'h0, q);
         chk("reset value", RV[i], q);
      end
      wb(1'b1, 5'h02, 32'hFF, q);
      wb(1'b0, 5'h02, 32'h0, q);
      chk("unmapped read", 32'h0, q);
      $display("reset test done");
      wb(1'b1, REG_MASK_LO, 32'h0, q);
      wb(1'b1, REG_MASK_HI, 32'h0, q);
      wb(1'b1, REG_EVT_MASK, 32'h7, q);
      m = 9'($urandom) | 9'h101;
      n0 = nTake;
      fire(m, 1'b0);
      repeat (40) @(posedge core_clk);
      chk("held while disabled", n0, nTake);
      while (m != 9'h0) begin
         n0 = nTake;
         wb(1'b1, REG_STATUS_WORD, 32'h82, q);
         take(top(m), n0);
         m[top(m)] = 1'b0;
         wb(1'b0, REG_REQ_LO, 32'h0, q);
         chk("flags after take", {24'h0, m[7:0]}, q);
      end
      chk("irq raised", 32'h1, {31'h0, irq});
      wb(1'b0, REG_EVT_STAT, 32'h0, q);
      chk("event status", 32'h2, q);
      chk("irq cleared", 32'h0, {31'h0, irq});
      $display("priority test done");
      wb(1'b1, REG_MASK_LO, 32'h1, q);
      fire(9'h001, 1'b0);
      fr <= 1'b1;
      wb(1'b1, REG_STATUS_WORD, 32'h82, q);
      n0 = nTake;
      repeat (40) @(posedge core_clk);
      chk("masked held", n0, nTake);
      fr <= 1'b0;
      wb(1'b1, REG_MASK_LO, 32'h0, q);
      take(4'h0, n0);
      $display("mask test done");
      n0 = nTake;
      fire(9'h010, 1'b1);
      take(NMI_IDX, n0);
      chk("nmi kind", 32'h1, {31'h0, lastNmi});
      chk("enable after take", 32'h0, {31'h0, enFlag});
      n0 = nTake;
      fire(9'h000, 1'b1);
      take(NMI_IDX, n0);
      n0 = nTake;
      retSt <= 8'h82;
      retReq <= 1'b1;
      while (seq.irqRetExec !== 1'b1) @(posedge core_clk);
      retReq <= 1'b0;
      take(4'h4, n0);
      wb(1'b0, REG_EVT_STAT, 32'h0, q);
      chk("event status", 32'h7, q);
      wb(1'b0, REG_WINNER, 32'h0, q);
      chk("winner index", 32'h4, q & 32'h2F);
      $display("nmi test done");
      complete_run();
   end
endmodule : interrupt_acknowledge_ctrl_test
`default_nettype wire
